/* File: logic/dcp_top.sv */
// register bank, power modes and self refresh arbitration
`timescale 1ns/1ps
`default_nettype none
module dcp_top
	import dcp_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        select_n,
	input  wire logic        reset_n_pin,
	input  wire logic        bus_clock,
	input  wire logic        clock_complement,
	input  wire logic        high_temp,
	output var  logic        strobe_out,
	output var  logic        strobe_oe,
	output var  logic [2:0]  drive_strength,
	output var  logic        clock_complement_en,
	output var  logic        hybrid_sleep,
	output var  logic        deep_power_down,
	output var  logic        array_valid,
	output var  logic        refresh_active,
	output var  logic [2:0]  refresh_region
);
	////////////////////////////////////////////////////////////////
	// input synchronisers
	logic cs_n_s;
	logic rst_pin_n_s;
	logic temp_s;
	logic clk_s;
	logic cmp_s;
	logic [4:0] sync_in;
	logic [4:0] sync_out;
	assign sync_in = {select_n, reset_n_pin, high_temp, bus_clock,
		clock_complement};
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			dcp_sync u_sync (
				.pclk    (pclk),
				.presetn (presetn),
				.rst_val (gi == 3 || gi == 4),
				.din     (sync_in[gi] ^ (gi == 3 || gi == 4)),
				.dout    (sync_out[gi])
			);
		end
	endgenerate
	assign cs_n_s      = sync_out[4] ^ 1'b0;
	assign rst_pin_n_s = sync_out[3];
	assign temp_s      = sync_out[2];
	assign clk_s       = sync_out[1];
	assign cmp_s       = sync_out[0];
	////////////////////////////////////////////////////////////////
	// state
	logic [15:0] cr0;
	logic [15:0] cr1;
	dcp_pwr_t    pwr;
	dcp_pwr_t    next_pwr;
	logic        cs_n_d;
	logic        clk_d;
	logic        cmp_d;
	logic        cs_fall;
	logic        cs_rise;
	logic        clk_edge;
	logic        in_ca;
	logic [2:0]  ca_cnt;
	logic [15:0] ref_cnt;
	logic [2:0]  busy_cnt;
	logic        ref_pend;
	logic [7:0]  pd_cnt;
	logic        pd_seen_low;
	logic        hw_rst;
	////////////////////////////////////////////////////////////////
	// bus decode
	wire         acc      = psel && penable;
	wire         hit_cr0  = (paddr == ADDR_CR0);
	wire         hit_cr1  = (paddr == ADDR_CR1);
	wire         hit_st   = (paddr == ADDR_STATUS);
	wire         mapped   = hit_cr0 || hit_cr1 || hit_st;
	wire         wr_ok    = acc && pwrite && &pstrb[1:0];
	wire         wr_cr0   = wr_ok && hit_cr0;
	wire         wr_cr1   = wr_ok && hit_cr1;
	wire  [1:0]  ref_code = temp_s ? REF_CODE_1US : REF_CODE_4US;
	wire  [15:0] cr1_view = {cr1[15:2], ref_code};
	wire  [15:0] status   = {11'h000, ref_pend, refresh_active,
		array_valid, deep_power_down, hybrid_sleep};
	wire  [15:0] rd_mux   = hit_cr0 ? cr0 : hit_cr1 ? cr1_view :
		hit_st ? status : 16'h0000;
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= {16'h0000, rd_mux};
	end
	////////////////////////////////////////////////////////////////
	// edge detection on synchronised pins
	assign cs_fall  = cs_n_d && !cs_n_s;
	assign cs_rise  = !cs_n_d && cs_n_s;
	assign clk_edge = (clk_d != clk_s) || (cmp_d != cmp_s && !cr1[CR1_CLK_BIT]);
	assign hw_rst   = !rst_pin_n_s;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_n_d <= 1'b1;
			clk_d  <= 1'b0;
			cmp_d  <= 1'b0;
		end else begin
			cs_n_d <= cs_n_s;
			clk_d  <= clk_s;
			cmp_d  <= cr1[CR1_CLK_BIT] ? 1'b0 : cmp_s;
		end
	end
	////////////////////////////////////////////////////////////////
	// power state machine
	wire pd_req = wr_cr0 && !pwdata[CR0_PD_BIT];
	always_comb begin
		next_pwr = pwr;
		unique case (pwr)
			DCP_RUN:     if (pd_req) next_pwr = DCP_PD_WAIT;
			DCP_PD_WAIT: if (pd_cnt == 8'(PD_ENTRY_CYC - 1)) next_pwr = DCP_PD;
			DCP_PD:      if (pd_seen_low && cs_rise) next_pwr = DCP_RUN;
		endcase
		if (hw_rst)
			next_pwr = DCP_RUN;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr         <= DCP_RUN;
			pd_cnt      <= 8'h00;
			pd_seen_low <= 1'b0;
		end else begin
			pwr         <= next_pwr;
			pd_cnt      <= (pwr == DCP_PD_WAIT) ? pd_cnt + 8'h01 : 8'h00;
			pd_seen_low <= (pwr == DCP_PD) && (pd_seen_low || cs_fall);
		end
	end
	wire in_pd = (pwr != DCP_RUN);
	////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cr0 <= CR0_RESET;
			cr1 <= CR1_RESET;
		end else if (hw_rst) begin
			cr0 <= CR0_RESET;
			cr1 <= CR1_RESET;
		end else begin
			if (pwr == DCP_PD && next_pwr == DCP_RUN)
				cr0[CR0_PD_BIT] <= 1'b1;
			else if (wr_cr0 && !in_pd)
				cr0 <= pwdata[15:0];
			if (in_pd)
				cr1 <= cr1;
			else if (wr_cr1)
				cr1 <= {pwdata[15:2], cr1[1:0]};
			else if (cs_fall && cr1[CR1_HS_BIT])
				cr1[CR1_HS_BIT] <= 1'b0;
		end
	end
	assign drive_strength      = cr0[CR0_DRV_LSB +: 3];
	assign clock_complement_en = !cr1[CR1_CLK_BIT];
	assign hybrid_sleep        = cr1[CR1_HS_BIT];
	assign deep_power_down     = (pwr == DCP_PD);
	assign refresh_region      = cr1[CR1_PAR_LSB +: 3];
	////////////////////////////////////////////////////////////////
	// array validity
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			array_valid <= 1'b0;
		else if (in_pd || hw_rst)
			array_valid <= 1'b0;
		else if (wr_cr0 && pwdata[CR0_PD_BIT])
			array_valid <= 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// self refresh timing and arbitration
	wire [15:0] ref_period = temp_s ? 16'(REF_1US_CYC) : 16'(REF_4US_CYC);
	wire        none_reg   = (refresh_region == 3'h4);
	wire        ref_due    = (ref_cnt >= ref_period - 16'h0001);
	wire        start_ref  = ref_pend && cs_n_s && busy_cnt == 3'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_cnt  <= 16'h0000;
			ref_pend <= 1'b0;
			busy_cnt <= 3'h0;
		end else if (in_pd || hw_rst || none_reg) begin
			ref_cnt  <= 16'h0000;
			ref_pend <= 1'b0;
			busy_cnt <= 3'h0;
		end else begin
			ref_cnt <= ref_due ? 16'h0000 : ref_cnt + 16'h0001;
			if (ref_due)
				ref_pend <= 1'b1;
			else if (start_ref)
				ref_pend <= 1'b0;
			if (start_ref)
				busy_cnt <= 3'(REF_BUSY_CYC);
			else if (busy_cnt != 3'h0)
				busy_cnt <= busy_cnt - 3'h1;
		end
	end
	assign refresh_active = (busy_cnt != 3'h0);
	////////////////////////////////////////////////////////////////
	// strobe in command-address phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_ca      <= 1'b0;
			ca_cnt     <= 3'h0;
			strobe_out <= 1'b0;
			strobe_oe  <= 1'b0;
		end else if (cs_n_s || in_pd) begin
			in_ca      <= 1'b0;
			ca_cnt     <= 3'h0;
			strobe_out <= 1'b0;
			strobe_oe  <= 1'b0;
		end else begin
			if (cs_fall) begin
				in_ca      <= 1'b1;
				strobe_oe  <= 1'b1;
				strobe_out <= cr0[CR0_FIXLAT_BIT]
					|| refresh_active || ref_pend;
			end else if (in_ca && clk_edge) begin
				ca_cnt <= ca_cnt + 3'h1;
				if (ca_cnt == 3'h5) begin
					in_ca     <= 1'b0;
					strobe_oe <= 1'b0;
				end
			end
		end
	end
endmodule // dcp_top
`default_nettype wire

/* File: logic/dcp_pkg.sv */
// constants and types for dram config, power and refresh control
// Function
// - cr0 drive strength field 14:12 sets impedance, resets to zero
// - clearing cr0 bit 15 enters deep power down, refresh stops
// - array contents treated invalid after leaving deep power down
// - deep power down exits on select low then high, or reset
// - in deep power down only select and reset are watched
// - cr1 bits 15:7 reset to all ones, host writes ones
// - cr1 bit 6 picks clock: one single-ended default, zero differential
// - single-ended mode keeps complement clock input disabled
// - writing one to cr1 bit 5 enters hybrid sleep
// - hybrid sleep retains contents with lower power
// - falling select in hybrid sleep wakes and clears the bit
// - reset ends hybrid sleep; refresh disabled, contents may be lost
// - cr1 field 4:2 limits refresh region, eight codes
// - cr1 bits 1:0 read only, report refresh interval code
// - self refresh spread evenly, never exceeding maximum interval
// - pending refresh waits for active access to end
// - access starting during refresh drives strobe high in address phase
// - fixed latency bit drives strobe high in every address phase
package dcp_pkg;
	localparam logic [11:0] ADDR_CR0        = 12'h000;
	localparam logic [11:0] ADDR_CR1        = 12'h004;
	localparam logic [11:0] ADDR_STATUS     = 12'h008;
	localparam int          CR0_PD_BIT      = 15;
	localparam int          CR0_DRV_LSB     = 12;
	localparam int          CR0_FIXLAT_BIT  = 3;
	localparam int          CR1_CLK_BIT     = 6;
	localparam int          CR1_HS_BIT      = 5;
	localparam int          CR1_PAR_LSB     = 2;
	localparam logic [15:0] CR0_RESET       = 16'h8f_8f;
	localparam logic [15:0] CR1_RESET       = 16'hff_c1;
	localparam logic [15:0] CR1_RSVD_MASK   = 16'hff_80;
	localparam logic [1:0]  REF_CODE_4US    = 2'h1;
	localparam logic [1:0]  REF_CODE_1US    = 2'h2;
	localparam int          CLK_MHZ         = 100;
	localparam int          REF_4US_NS      = 4000;
	localparam int          REF_1US_NS      = 1000;
	localparam int          REF_4US_CYC     = REF_4US_NS * CLK_MHZ / 1000;
	localparam int          REF_1US_CYC     = REF_1US_NS * CLK_MHZ / 1000;
	localparam int          REF_BUSY_CYC    = 4;
	localparam int          PD_ENTRY_NS     = 150;
	localparam int          PD_ENTRY_CYC    = PD_ENTRY_NS * CLK_MHZ / 1000;
	typedef enum logic [1:0] {
		DCP_RUN,
		DCP_PD_WAIT,
		DCP_PD
	} dcp_pwr_t;
endpackage

/* File: logic/dcp_sync.sv */
// three-flop synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dcp_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic rst_val,
	input  wire logic din,
	output var  logic dout
);
	logic s1;
	logic s2;
	logic s3;
	logic hold;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1   <= 1'b0;
			s2   <= 1'b0;
			s3   <= 1'b0;
			hold <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				hold <= s3;
		end
	end
	assign dout = hold ^ rst_val;
endmodule // dcp_sync
`default_nettype wire

/* File: dv/dcp_sva.sv */
// concurrent checks on the dcp_top ports
`timescale 1ns/1ps
`default_nettype none
module dcp_sva
	import dcp_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        select_n,
	input wire logic        strobe_out,
	input wire logic        strobe_oe,
	input wire logic [2:0]  drive_strength,
	input wire logic        hybrid_sleep,
	input wire logic        deep_power_down,
	input wire logic        array_valid,
	input wire logic        refresh_active,
	input wire logic [2:0]  refresh_region
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic wr  = psel && penable && pwrite && !deep_power_down;
	wire logic wr0 = wr && paddr == ADDR_CR0;
	wire logic wr1 = wr && paddr == ADDR_CR1;
	property p_drive; wr0 |=> drive_strength == $past(pwdata[14:12]);
	endproperty
	a_drive: assert property (p_drive) else $error("drive field");
	property p_pd_in; wr0 && !pwdata[15] |-> ##[1:20] deep_power_down;
	endproperty
	a_pd_in: assert property (p_pd_in) else $error("no power down");
	property p_pd_inv; deep_power_down |-> !array_valid &&
		(!$past(deep_power_down, 4) || !refresh_active); endproperty
	a_pd_inv: assert property (p_pd_inv) else $error("dpd activity");
	property p_pd_out; deep_power_down && $rose(select_n) |->
		##[1:8] !deep_power_down; endproperty
	a_pd_out: assert property (p_pd_out) else $error("dpd stuck");
	property p_wake; hybrid_sleep && $fell(select_n) |->
		##[1:6] !hybrid_sleep; endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_region; wr1 |=> refresh_region == $past(pwdata[4:2]);
	endproperty
	a_region: assert property (p_region) else $error("region");
	property p_noref; !select_n [*6] |-> !$rose(refresh_active); endproperty
	a_noref: assert property (p_noref) else $error("refresh in access");
	property p_strobe; $rose(strobe_oe) && $past(refresh_active) |->
		strobe_out; endproperty
	a_strobe: assert property (p_strobe) else $error("strobe low");
	c_pd: cover property ($rose(deep_power_down));
	c_wake: cover property ($fell(hybrid_sleep));
	c_oe: cover property ($rose(strobe_oe) && strobe_out);
endmodule // dcp_sva
bind dcp_top dcp_sva dcp_sva_i (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .select_n, .strobe_out, .strobe_oe, .drive_strength,
	.hybrid_sleep, .deep_power_down, .array_valid, .refresh_active,
	.refresh_region);
`default_nettype wire

/* File: dv/dcp_host.sv */
// host controller model on the link pins
`timescale 1ns/1ps
`default_nettype none
module dcp_host (
	output var  logic select_n,
	output var  logic bus_clock,
	output wire logic clock_complement,
	input  wire logic strobe_out,
	input  wire logic strobe_oe
);
	initial {select_n, bus_clock} = 2'b10;
	assign clock_complement = !bus_clock;
	// short frames, select low well under the refresh interval
	task automatic frame(input int edges, output logic seen);
		#3 select_n = 1'b0;
		seen = 1'b0;
		for (int i = 0; i < edges; i++) begin
			#80 bus_clock = !bus_clock;
			if (i == 1)
				seen = strobe_oe && strobe_out;
		end
		#80 select_n = 1'b1;
	endtask
endmodule // dcp_host
`default_nettype wire

/* File: dv/dram_config_power_refresh_tb.sv */
// bench for the dram config, power and refresh block
`timescale 1ns/1ps
`default_nettype none
`define check_eq(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
	failures++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module dram_config_power_refresh_tb;
	import dcp_pkg::*;
	typedef struct packed {logic [11:0] addr; logic [31:0] wdata;
		logic [15:0] mask; logic [15:0] exp;} dcp_row_t;
	dcp_row_t    rows[12];
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        reset_n_pin = 1, high_temp = 0, seen, pready, pslverr;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [2:0]  drive_strength, refresh_region;
	logic        select_n, bus_clock, clock_complement, strobe_out, strobe_oe;
	logic        clock_complement_en, hybrid_sleep, deep_power_down;
	logic        array_valid, refresh_active, serr;
	int          failures = 0, checks = 0, n;
	dcp_top dcp_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .select_n,
		.reset_n_pin, .bus_clock, .clock_complement, .high_temp, .strobe_out,
		.strobe_oe, .drive_strength, .clock_complement_en, .hybrid_sleep,
		.deep_power_down, .array_valid, .refresh_active, .refresh_region);
	dcp_host dcp_host_i (.select_n, .bus_clock, .clock_complement,
		.strobe_out, .strobe_oe);
	initial forever #5 pclk = !pclk;
	initial begin
		#50000 failures++;
		tally_and_finish();
	end
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		{psel, penable} <= 2'b00;
		#1;
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, ADDR_CR0, 0);
		`check_eq("cr0", 16'h8008, rd[15:0] & 16'hf008)
		apb(0, ADDR_CR1, 0);
		`check_eq("cr1", 16'hffc1, rd[15:0])
		`check_eq("pins", 4'h0, {drive_strength, clock_complement_en})
		for (int i = 0; i < 8; i++)
			rows[i] = {ADDR_CR1, 32'hffc2 | 32'(i << 2), 16'hffff,
				16'hffc1 | 16'(i << 2)};
		for (int i = 5; i < 8; i++)
			rows[i + 3] = {ADDR_CR0, 32'h8f8f | 32'(i << 12), 16'h7000,
				16'(i << 12)};
		rows[11] = {12'h00c, 32'hffff, 16'hffff, 16'h0};
		foreach (rows[i]) begin
			apb(1, rows[i].addr, rows[i].wdata);
			apb(0, rows[i].addr, 0);
			`check_eq("row", rows[i].exp, rd[15:0] & rows[i].mask)
		end
		`check_eq("slverr", 1'b1, serr)
		high_temp <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(0, ADDR_CR1, 0);
		`check_eq("hot code", 2'b10, rd[1:0])
		apb(1, ADDR_CR1, 32'hffd1);
		repeat (10) @(posedge pclk);
		n = 0;
		repeat (500) @(posedge pclk) n += refresh_active;
		`check_eq("no refresh", 0, n)
		apb(1, ADDR_CR1, 32'hff81);
		`check_eq("diff", 1'b1, clock_complement_en)
		apb(1, ADDR_CR1, 32'hffe1);
		`check_eq("hs on", 2'b01, {clock_complement_en, hybrid_sleep})
		repeat (401) @(posedge pclk) n += refresh_active;
		`check_eq("refresh in hs", 1'b1, n > 0)
		dcp_host_i.frame(6, seen);
		apb(0, ADDR_CR1, 0);
		`check_eq("woken", 3'b100, {seen, hybrid_sleep, rd[5]})
		apb(1, ADDR_CR0, 32'h0f8f);
		repeat (20) @(posedge pclk);
		#1 `check_eq("dpd", 2'b10, {deep_power_down, array_valid})
		apb(1, ADDR_CR1, 32'hffe1);
		`check_eq("ignored", 1'b0, hybrid_sleep)
		dcp_host_i.frame(2, seen);
		repeat (8) @(posedge pclk);
		apb(0, ADDR_CR0, 0);
		`check_eq("exit", 3'b100, {rd[15], deep_power_down, array_valid})
		apb(1, ADDR_CR1, 32'hffe1);
		apb(1, ADDR_CR0, 32'h7f8f);
		repeat (20) @(posedge pclk);
		reset_n_pin <= 1'b0;
		repeat (8) @(posedge pclk);
		reset_n_pin <= 1'b1;
		repeat (8) @(posedge pclk);
		#1 `check_eq("pin", 5'h0, {drive_strength, hybrid_sleep, deep_power_down})
		tally_and_finish();
	end
endmodule // dram_config_power_refresh_tb
`default_nettype wire
